/* File: hw/cct_timer.sv */
// Implementation choices: strobed register access and the address map.
`timescale 1ns/10ps
`include "cct_timer_cfg.svh"

module cct_timer #(
  parameter int NUM_CH = 6
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire cct_pkg::cct_addr_t addr_i,
  input wire cct_pkg::cct_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output cct_pkg::cct_byte_t rdata_o,
  input wire logic external_count_clock_i,
  input wire logic [NUM_CH-1:0] ch_pin_i,
  output logic [NUM_CH-1:0] ch_pin_o,
  output logic [NUM_CH-1:0] ch_pin_oe_o,
  output logic overflow_irq_o,
  output logic [NUM_CH-1:0] ch_irq_o
);
  import cct_pkg::*;

  // The address map reaches only a few channels and pairing needs an even count.
  if (NUM_CH < 2 || NUM_CH > 8 || (NUM_CH % 2) != 0) begin : g_bad_num_ch
    $error("NUM_CH must be even and between 2 and 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Low-bit mask of the prescaler that must be all ones for a divided tick.
  function automatic logic [5:0] div_mask(input logic [2:0] sel);
    logic [6:0] m;
    m = (7'h01 << sel) - 7'h01;
    return m[5:0];
  endfunction : div_mask

  // Byte address of one register of channel ch.
  function automatic cct_addr_t ch_addr(input int unsigned ch, input int unsigned sub);
    return 5'(`CCT_CH_BASE + `CCT_CH_STRIDE * ch + sub);
  endfunction : ch_addr

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic halt_ff, ovf_ie_ff, ovf_flag_ff, ovf_arm_ff, mod_lock_ff, cnt_latched_ff;
  logic [2:0] clk_sel_ff;
  logic [5:0] presc_ff;
  cct_word_t cnt_ff, mod_ff;
  cct_byte_t mod_hi_buf_ff, cnt_lo_latch_ff, rdata_ff;
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
  logic [NUM_CH-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic [NUM_CH-1:0] chf_ff, chie_ff, msb_ff, msa_ff, tov_ff, ch_arm_ff, out_ff;
  logic [1:0] els_ff [NUM_CH];
  cct_word_t val_ff [NUM_CH];
  cct_byte_t val_hi_buf_ff [NUM_CH];
  logic [NUM_CH/2-1:0] sel_odd_ff, next_odd_ff;

  logic wr_sc, rd_sc, crst_wr, tick, wrap, ovf_evt;
  logic [NUM_CH-1:0] disabled, evt, match, ch_wr_sc, ch_rd_sc, ch_wr_lo;
  cct_mode_t mode [NUM_CH];
  cct_word_t cmp_val [NUM_CH];
  cct_byte_t nxt_rdata;

  assign wr_sc = wr_i && (addr_i == `CCT_A_SC);
  assign rd_sc = rd_i && (addr_i == `CCT_A_SC);
  assign crst_wr = wr_sc && wdata_i[`CCT_B_CRST];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      ext_s1_ff <= external_count_clock_i;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      pin_s1_ff <= ch_pin_i;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter.

  // A tick comes from the divided bus clock or a rising external edge.
  always_comb begin
    if (halt_ff) begin
      tick = 1'b0;
    end else if (clk_sel_ff == `CCT_CLKSEL_EXT) begin
      tick = ext_s2_ff && !ext_s3_ff;
    end else begin
      tick = &(presc_ff | ~div_mask(clk_sel_ff));
    end
  end

  assign wrap = tick && (cnt_ff == mod_ff) && !crst_wr;
  // A pending period high byte masks the flag, so a half-written period cannot fire.
  assign ovf_evt = wrap && !mod_lock_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_ff <= '0;
    end else if (crst_wr) begin
      presc_ff <= '0;
    end else if (!halt_ff) begin
      presc_ff <= presc_ff + 6'h01;
    end
  end

  // Counter reset wins over a tick, so halt plus reset parks it at zero.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (crst_wr) begin
      cnt_ff <= '0;
    end else if (wrap) begin
      cnt_ff <= '0;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer status and control register.

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_ff <= `CCT_HALT_RST;
      ovf_ie_ff <= 1'b0;
      clk_sel_ff <= `CCT_CLKSEL_RST;
    end else if (wr_sc) begin
      halt_ff <= wdata_i[`CCT_B_HALT];
      ovf_ie_ff <= wdata_i[`CCT_B_OVFIE];
      clk_sel_ff <= wdata_i[2:0];
    end
  end

  // The set beats the clear; a write of one never touches the flag.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_flag_ff <= 1'b0;
      ovf_arm_ff <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_ff <= 1'b1;
      ovf_arm_ff <= 1'b0;
    end else if (wr_sc) begin
      if (ovf_arm_ff && !wdata_i[`CCT_B_OVF]) begin
        ovf_flag_ff <= 1'b0;
      end
      ovf_arm_ff <= 1'b0;
    end else if (rd_sc && ovf_flag_ff) begin
      ovf_arm_ff <= 1'b1;
    end
  end

  assign overflow_irq_o = ovf_flag_ff && ovf_ie_ff && !mod_lock_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Period register and counter read latch.

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mod_ff <= `CCT_MOD_RST;
      mod_hi_buf_ff <= `CCT_MODH_RST;
      mod_lock_ff <= 1'b0;
    end else if (wr_i && addr_i == `CCT_A_MODH) begin
      mod_hi_buf_ff <= wdata_i;
      mod_lock_ff <= 1'b1;
    end else if (wr_i && addr_i == `CCT_A_MODL) begin
      mod_ff <= {mod_hi_buf_ff, wdata_i};
      mod_lock_ff <= 1'b0;
    end
  end

  // The latch keeps a 16-bit read coherent across two byte reads.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_lo_latch_ff <= '0;
      cnt_latched_ff <= 1'b0;
    end else if (crst_wr) begin
      cnt_lo_latch_ff <= '0;
      cnt_latched_ff <= 1'b0;
    end else if (rd_i && addr_i == `CCT_A_CNTH && !cnt_latched_ff) begin
      cnt_lo_latch_ff <= cnt_ff[7:0];
      cnt_latched_ff <= 1'b1;
    end else if (rd_i && addr_i == `CCT_A_CNTL) begin
      cnt_latched_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel decode and events.

  always_comb begin
    for (int p = 0; p < NUM_CH / 2; p++) begin
      disabled[2*p] = 1'b0;
      disabled[2*p+1] = msb_ff[2*p];
      cmp_val[2*p] = (msb_ff[2*p] && sel_odd_ff[p]) ? val_ff[2*p+1] : val_ff[2*p];
      cmp_val[2*p+1] = val_ff[2*p+1];
    end
    for (int i = 0; i < NUM_CH; i++) begin
      ch_wr_sc[i] = wr_i && addr_i == ch_addr(i, `CCT_CH_SUB_SC) && !disabled[i];
      ch_rd_sc[i] = rd_i && addr_i == ch_addr(i, `CCT_CH_SUB_SC) && !disabled[i];
      ch_wr_lo[i] = wr_i && addr_i == ch_addr(i, `CCT_CH_SUB_LO);
      if (els_ff[i] == `CCT_ELS_OFF || disabled[i]) begin
        mode[i] = CCT_MODE_OFF;
      end else if (msb_ff[i] || msa_ff[i]) begin
        mode[i] = CCT_MODE_COMPARE;
      end else begin
        mode[i] = CCT_MODE_CAPTURE;
      end
      match[i] = (mode[i] == CCT_MODE_COMPARE) && tick && !crst_wr && (cnt_ff == cmp_val[i]);
      evt[i] = match[i];
      if (mode[i] == CCT_MODE_CAPTURE && !halt_ff) begin
        case (els_ff[i])
          `CCT_ELS_RISE_TGL: evt[i] = pin_s2_ff[i] && !pin_s3_ff[i];
          `CCT_ELS_FALL_LOW: evt[i] = !pin_s2_ff[i] && pin_s3_ff[i];
          `CCT_ELS_ANY_HIGH: evt[i] = pin_s2_ff[i] != pin_s3_ff[i];
          default: evt[i] = 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel status and control registers.

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chie_ff <= '0;
      msb_ff <= '0;
      msa_ff <= '0;
      tov_ff <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        els_ff[i] <= `CCT_ELS_OFF;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_wr_sc[i]) begin
          chie_ff[i] <= wdata_i[`CCT_B_CHIE];
          msb_ff[i] <= (i % 2 == 0) ? wdata_i[`CCT_B_MSB] : 1'b0;
          msa_ff[i] <= wdata_i[`CCT_B_MSA];
          els_ff[i] <= wdata_i[`CCT_B_ELSH:`CCT_B_ELSL];
          tov_ff[i] <= wdata_i[`CCT_B_TOV];
        end
      end
    end
  end

  // Channel flags: an event in the clearing cycle keeps the flag set.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chf_ff <= '0;
      ch_arm_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (evt[i]) begin
          chf_ff[i] <= 1'b1;
          ch_arm_ff[i] <= 1'b0;
        end else if (ch_wr_sc[i]) begin
          if (ch_arm_ff[i] && !wdata_i[`CCT_B_CHF]) begin
            chf_ff[i] <= 1'b0;
          end
          ch_arm_ff[i] <= 1'b0;
        end else if (ch_rd_sc[i] && chf_ff[i]) begin
          ch_arm_ff[i] <= 1'b1;
        end
      end
    end
  end

  assign ch_irq_o = chf_ff & chie_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Channel values; the high byte waits in a buffer so a compare never sees half a value.

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        val_ff[i] <= '0;
        val_hi_buf_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (mode[i] == CCT_MODE_CAPTURE && evt[i]) begin
          val_ff[i] <= cnt_ff;
        end else if (ch_wr_lo[i]) begin
          val_ff[i] <= {val_hi_buf_ff[i], wdata_i};
        end
        if (wr_i && addr_i == ch_addr(i, `CCT_CH_SUB_HI)) begin
          val_hi_buf_ff[i] <= wdata_i;
        end
      end
    end
  end

  // The pair follows the registers written last, switching only at a wrap.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_odd_ff <= '0;
      next_odd_ff <= '0;
    end else begin
      for (int p = 0; p < NUM_CH / 2; p++) begin
        if (!msb_ff[2*p]) begin
          sel_odd_ff[p] <= 1'b0;
          next_odd_ff[p] <= 1'b0;
        end else begin
          if (ch_wr_lo[2*p]) begin
            next_odd_ff[p] <= 1'b0;
          end else if (ch_wr_lo[2*p+1]) begin
            next_odd_ff[p] <= 1'b1;
          end
          if (wrap) begin
            sel_odd_ff[p] <= next_odd_ff[p];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel outputs.

  // A wrap toggle outranks a match so PWM edges stay aligned to the period.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_ff <= '1;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (els_ff[i] == `CCT_ELS_OFF) begin
          out_ff[i] <= !msa_ff[i];
        end else if (mode[i] == CCT_MODE_COMPARE) begin
          if (wrap && tov_ff[i]) begin
            out_ff[i] <= !out_ff[i];
          end else if (match[i]) begin
            case (els_ff[i])
              `CCT_ELS_RISE_TGL: out_ff[i] <= !out_ff[i];
              `CCT_ELS_FALL_LOW: out_ff[i] <= 1'b0;
              `CCT_ELS_ANY_HIGH: out_ff[i] <= 1'b1;
              default: out_ff[i] <= out_ff[i];
            endcase
          end
        end
      end
    end
  end

  assign ch_pin_o = out_ff;

  // Only compare channels drive; capture pins stay inputs, off pins go to the port.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ch_pin_oe_o[i] = (mode[i] == CCT_MODE_COMPARE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe.

  always_comb begin
    nxt_rdata = '0;
    case (addr_i)
      `CCT_A_SC: nxt_rdata = {ovf_flag_ff, ovf_ie_ff, halt_ff, 1'b0, 1'b0, clk_sel_ff};
      `CCT_A_CNTH: nxt_rdata = cnt_ff[15:8];
      `CCT_A_CNTL: nxt_rdata = cnt_latched_ff ? cnt_lo_latch_ff : cnt_ff[7:0];
      `CCT_A_MODH: nxt_rdata = mod_hi_buf_ff;
      `CCT_A_MODL: nxt_rdata = mod_ff[7:0];
      default: nxt_rdata = '0;
    endcase
    for (int i = 0; i < NUM_CH; i++) begin
      if (addr_i == ch_addr(i, `CCT_CH_SUB_SC) && !disabled[i]) begin
        nxt_rdata = {chf_ff[i], chie_ff[i], msb_ff[i], msa_ff[i], els_ff[i], tov_ff[i], 1'b0};
      end else if (addr_i == ch_addr(i, `CCT_CH_SUB_HI)) begin
        nxt_rdata = val_ff[i][15:8];
      end else if (addr_i == ch_addr(i, `CCT_CH_SUB_LO)) begin
        nxt_rdata = val_ff[i][7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= rd_i ? nxt_rdata : 8'h00;
    end
  end

  assign rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_ovf_set;
    tick && (cnt_ff == mod_ff) && !crst_wr && !mod_lock_ff |=> ovf_flag_ff;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set at period");

  property p_ovf_one_keeps;
    ovf_flag_ff && wr_sc && wdata_i[`CCT_B_OVF] |=> ovf_flag_ff;
  endproperty
  a_ovf_one_keeps: assert property (p_ovf_one_keeps) else $error("writing one cleared overflow flag");

  property p_ovf_clear_armed;
    $fell(ovf_flag_ff) |-> $past(wr_sc) && $past(ovf_arm_ff);
  endproperty
  a_ovf_clear_armed: assert property (p_ovf_clear_armed) else $error("overflow flag cleared unarmed");

  property p_irq_follow;
    wr_sc && wdata_i[`CCT_B_OVFIE] && wdata_i[`CCT_B_OVF] && ovf_flag_ff && !mod_lock_ff |=> overflow_irq_o;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("overflow interrupt missing");

  property p_halt_hold;
    halt_ff && !crst_wr |=> $stable(cnt_ff);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("counter moved while halted");

  property p_halt_no_evt;
    halt_ff |-> evt == '0;
  endproperty
  a_halt_no_evt: assert property (p_halt_no_evt) else $error("channel event while halted");

  property p_crst_zero;
    crst_wr && wdata_i[`CCT_B_HALT] |=> (cnt_ff == 16'h0000) [*2];
  endproperty
  a_crst_zero: assert property (p_crst_zero) else $error("counter not parked at zero");

  property p_wrap_zero;
    tick && (cnt_ff == mod_ff) && !crst_wr |=> cnt_ff == 16'h0000;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("counter did not restart");

  property p_lock_blocks;
    mod_lock_ff |=> !$rose(ovf_flag_ff);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("overflow during period update");

  property p_increment;
    tick && (cnt_ff != mod_ff) && !crst_wr |=> cnt_ff == $past(cnt_ff) + 16'h0001;
  endproperty
  a_increment: assert property (p_increment) else $error("counter did not step by one");

  c_overflow: cover property (ovf_evt);
  c_capture: cover property (evt[0] && mode[0] == CCT_MODE_CAPTURE);
  c_match: cover property (match[0] ##1 ch_irq_o[0]);
  c_pair_switch: cover property (wrap && sel_odd_ff[0] != next_odd_ff[0]);

endmodule : cct_timer

/* File: hw/cct_timer_cfg.svh */
`ifndef CCT_TIMER_CFG_SVH
`define CCT_TIMER_CFG_SVH

// Register addresses on the byte-wide register port.
`define CCT_A_SC 5'h00
`define CCT_A_CNTH 5'h01
`define CCT_A_CNTL 5'h02
`define CCT_A_MODH 5'h03
`define CCT_A_MODL 5'h04
// Channel x: status/control at base+3x, value high at +1, value low at +2.
`define CCT_CH_BASE 5
`define CCT_CH_STRIDE 3
`define CCT_CH_SUB_SC 0
`define CCT_CH_SUB_HI 1
`define CCT_CH_SUB_LO 2

// Timer status and control bit positions.
`define CCT_B_OVF 7
`define CCT_B_OVFIE 6
`define CCT_B_HALT 5
`define CCT_B_CRST 4
`define CCT_CLKSEL_EXT 3'h7

// Channel status and control bit positions.
`define CCT_B_CHF 7
`define CCT_B_CHIE 6
`define CCT_B_MSB 5
`define CCT_B_MSA 4
`define CCT_B_ELSH 3
`define CCT_B_ELSL 2
`define CCT_B_TOV 1

// Edge/level field codes.
`define CCT_ELS_OFF 2'h0
`define CCT_ELS_RISE_TGL 2'h1
`define CCT_ELS_FALL_LOW 2'h2
`define CCT_ELS_ANY_HIGH 2'h3

// Reset values.
`define CCT_MOD_RST 16'hFFFF
`define CCT_MODH_RST 8'hFF
`define CCT_HALT_RST 1'b1
`define CCT_CLKSEL_RST 3'h0

`endif

/* File: hw/cct_pkg.sv */
package cct_pkg;
  typedef logic [7:0] cct_byte_t;
  typedef logic [4:0] cct_addr_t;
  typedef logic [15:0] cct_word_t;
  typedef enum {CCT_MODE_OFF, CCT_MODE_CAPTURE, CCT_MODE_COMPARE} cct_mode_t;
endpackage : cct_pkg

/* File: tb/cct_pin_model.sv */
`timescale 1ns/10ps
// Far side of the channel pins and of the external count clock input.
module cct_pin_model (
  input wire logic clk_i,
  input wire logic [5:0] pin_out_i,
  input wire logic [5:0] pin_oe_i,
  input wire logic [5:0] src_lvl_i,
  input wire logic ext_run_i,
  output logic [5:0] pin_o,
  output logic ext_clk_o
);
  logic [1:0] div_ff;

  // A driving channel owns its wire; otherwise the outside source sets the level.
  assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & src_lvl_i);

  ////////////////////////////////////////////////////////////////////////////
  // Count clock at one eighth of the bus clock, which keeps each phase well above one bus period.
  // It stands low while not running, so no stray tick reaches the counter.
  always_ff @(posedge clk_i) begin
    div_ff <= ext_run_i ? div_ff + 2'h1 : 2'h0;
    if (!ext_run_i) begin
      ext_clk_o <= 1'b0;
    end else if (div_ff == 2'h3) begin
      ext_clk_o <= ~ext_clk_o;
    end
  end
endmodule : cct_pin_model

/* File: tb/cct_timer_tb.sv */
`timescale 1ns/10ps
`include "cct_timer_cfg.svh"
module cct_timer_tb;
  import cct_pkg::*;
  logic clk_i, rst_n_i, wr_i, rd_i, ext_run, ext_clk;
  cct_addr_t addr_i;
  cct_byte_t wdata_i, rdata_o, v1, v2;
  logic [5:0] pin_in, pin_out, pin_oe, src_lvl, ch_irq;
  logic ovf_irq, b1, b2;
  int n_fail = 0;
  int tests_run = 0;

  cct_timer u_cct_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .external_count_clock_i(ext_clk), .ch_pin_i(pin_in), .ch_pin_o(pin_out),
    .ch_pin_oe_o(pin_oe), .overflow_irq_o(ovf_irq), .ch_irq_o(ch_irq));
  cct_pin_model u_cct_pin_model (.clk_i(clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .src_lvl_i(src_lvl),
    .ext_run_i(ext_run), .pin_o(pin_in), .ext_clk_o(ext_clk));

  ////////////////////////////////////////////////////////////////////////////
  // Clock generation.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Bus cycles; the read data are taken in the single cycle where they stand.
  task automatic wr(input cct_addr_t a, input cct_byte_t d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    // Step past the edge so checks that follow see the registers it updated.
    #1;
  endtask : wr

  task automatic rd(input cct_addr_t a, output cct_byte_t d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic chk(input string n, input cct_byte_t e, input cct_byte_t g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic rchk(input cct_addr_t a, input cct_byte_t e, input string n);
    cct_byte_t d;
    rd(a, d);
    chk(n, e, d);
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  function automatic cct_addr_t cha(input int ch, input int sub);
    return cct_addr_t'(`CCT_CH_BASE + `CCT_CH_STRIDE * ch + sub);
  endfunction : cha

  task automatic end_of_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog; the whole sequence needs only about 1200 cycles.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst_n_i = 1'b0;
    {wr_i, rd_i, ext_run} = 3'h0;
    addr_i = 5'h00;
    wdata_i = 8'h00;
    src_lvl = 6'h00;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rchk(`CCT_A_SC, 8'h20, "sc_reset");
    rchk(`CCT_A_MODH, 8'hFF, "modh_reset");
    rchk(`CCT_A_MODL, 8'hFF, "modl_reset");
    rchk(`CCT_A_CNTH, 8'h00, "cnth_reset");
    rchk(5'h1F, 8'h00, "unmapped");
    // A halted counter holds still and capture edges are ignored.
    wr(cha(3, `CCT_CH_SUB_SC), 8'h4C);
    @(posedge clk_i);
    src_lvl[3] <= 1'b1;
    cyc(20);
    rchk(`CCT_A_CNTL, 8'h00, "cnt_halted");
    rchk(cha(3, `CCT_CH_SUB_SC), 8'h4C, "cap_halted");
    src_lvl[3] <= 1'b0;
    // Every clock source gives exactly four ticks over four of its periods.
    for (int cs = 0; cs < 8; cs++) begin
      ext_run <= (cs == 7);
      wr(`CCT_A_SC, cct_byte_t'(cs));
      rd(`CCT_A_CNTL, v1);
      cyc((cs == 7) ? 30 : 4 * (1 << cs) - 2);
      rd(`CCT_A_CNTL, v2);
      chk("ticks", 8'h04, v2 - v1);
    end
    ext_run <= 1'b0;
    // The low byte stays latched across a second high-byte read.
    wr(`CCT_A_SC, 8'h06);
    rd(`CCT_A_CNTH, v1);
    cyc(200);
    rd(`CCT_A_CNTH, v1);
    rd(`CCT_A_CNTL, v1);
    rd(`CCT_A_CNTL, v2);
    chk("latch", 8'h01, {7'h0, (v2 - v1 == 8'h03) || (v2 - v1 == 8'h04)});
    wr(`CCT_A_SC, 8'h30);
    rd(`CCT_A_SC, v1);
    chk("crst_rd", 8'h20, v1 & 8'h3F);
    cyc(10);
    rchk(`CCT_A_CNTH, 8'h00, "cnth_crst");
    rchk(`CCT_A_CNTL, 8'h00, "cntl_crst");
    // Period of ten counts; the counter never passes the period value.
    wr(`CCT_A_MODH, 8'h00);
    wr(`CCT_A_MODL, 8'h09);
    wr(`CCT_A_SC, 8'h10);
    for (int i = 0; i < 12; i++) begin
      rd(`CCT_A_CNTL, v1);
      chk("wrap", 8'h01, {7'h0, v1 <= 8'h09});
    end
    wr(`CCT_A_SC, 8'h60);
    chk("ovf_irq", 8'h01, {7'h0, ovf_irq});
    wr(`CCT_A_SC, 8'h20);
    chk("ovf_irq_mask", 8'h00, {7'h0, ovf_irq});
    wr(`CCT_A_SC, 8'h60);
    rchk(`CCT_A_SC, 8'hE0, "ovf_set");
    wr(`CCT_A_SC, 8'hE0);
    rchk(`CCT_A_SC, 8'hE0, "ovf_w1");
    wr(`CCT_A_SC, 8'h60);
    rchk(`CCT_A_SC, 8'h60, "ovf_clr");
    chk("ovf_irq_clr", 8'h00, {7'h0, ovf_irq});
    // An overflow between the status read and the clearing write wins.
    wr(`CCT_A_SC, 8'h40);
    cyc(12);
    rd(`CCT_A_SC, v1);
    cyc(12);
    wr(`CCT_A_SC, 8'h40);
    rd(`CCT_A_SC, v1);
    chk("ovf_wins", 8'h80, v1 & 8'h80);
    // A lone period high-byte write blocks the flag until the low byte follows.
    wr(`CCT_A_SC, 8'h30);
    rd(`CCT_A_SC, v1);
    wr(`CCT_A_SC, 8'h20);
    wr(`CCT_A_MODH, 8'h00);
    wr(`CCT_A_SC, 8'h00);
    cyc(30);
    rchk(`CCT_A_SC, 8'h00, "modh_block");
    wr(`CCT_A_MODL, 8'h09);
    cyc(12);
    rd(`CCT_A_SC, v1);
    chk("modl_release", 8'h80, v1 & 8'h80);
    // Compare on channel 1 for each pin action, from a preset level.
    for (int c = 1; c < 4; c++) begin
      wr(`CCT_A_SC, 8'h30);
      wr(cha(1, `CCT_CH_SUB_HI), 8'h00);
      wr(cha(1, `CCT_CH_SUB_LO), 8'h05);
      wr(cha(1, `CCT_CH_SUB_SC), (c == 2) ? 8'h00 : 8'h10);
      cyc(1); // The preset level follows mode bit A one cycle after the write.
      chk("preset", {7'h0, c == 2}, {7'h0, pin_out[1]});
      chk("oe_off", 8'h00, {7'h0, pin_oe[1]});
      wr(cha(1, `CCT_CH_SUB_SC), cct_byte_t'(8'h50 | (c << 2)));
      chk("oe_on", 8'h01, {7'h0, pin_oe[1]});
      wr(`CCT_A_SC, 8'h00);
      cyc(10);
      chk("cmp_pin", {7'h0, c != 2}, {7'h0, pin_out[1]});
      chk("cmp_irq", 8'h01, {7'h0, ch_irq[1]});
      wr(`CCT_A_SC, 8'h20);
      wr(cha(1, `CCT_CH_SUB_SC), cct_byte_t'(8'h10 | (c << 2)));
      chk("irq_mask", 8'h00, {7'h0, ch_irq[1]});
      rd(cha(1, `CCT_CH_SUB_SC), v1);
      wr(cha(1, `CCT_CH_SUB_SC), cct_byte_t'(8'h10 | (c << 2)));
      rchk(cha(1, `CCT_CH_SUB_SC), cct_byte_t'(8'h10 | (c << 2)), "ch_clr");
    end
    // Buffered mode on channel 0 takes channel 1 off its pin and register.
    wr(cha(0, `CCT_CH_SUB_SC), 8'h20);
    rchk(cha(1, `CCT_CH_SUB_SC), 8'h00, "odd_off");
    chk("odd_oe", 8'h00, {7'h0, pin_oe[1]});
    wr(cha(0, `CCT_CH_SUB_SC), 8'h00);
    // Toggle at wrap on channel 2, with a compare value that never matches.
    wr(`CCT_A_SC, 8'h30);
    wr(cha(2, `CCT_CH_SUB_HI), 8'h00);
    wr(cha(2, `CCT_CH_SUB_LO), 8'hFF);
    for (int t = 1; t >= 0; t--) begin
      wr(cha(2, `CCT_CH_SUB_SC), cct_byte_t'(8'h14 | (t << 1)));
      wr(`CCT_A_SC, 8'h00);
      cyc(3);
      b1 = pin_out[2];
      cyc(10);
      b2 = pin_out[2];
      chk("tov", {7'h0, b1 ^ t[0]}, {7'h0, b2});
    end
    // Capture on channel 3 for each edge selection, counter running.
    for (int c = 1; c < 4; c++) begin
      wr(cha(3, `CCT_CH_SUB_SC), cct_byte_t'(c << 2));
      @(posedge clk_i);
      src_lvl[3] <= 1'b1;
      cyc(8);
      rd(cha(3, `CCT_CH_SUB_SC), v1);
      chk("cap_rise", {7'h0, c != 2}, {7'h0, v1[7]});
      wr(cha(3, `CCT_CH_SUB_SC), cct_byte_t'(c << 2));
      src_lvl[3] <= 1'b0;
      cyc(8);
      rd(cha(3, `CCT_CH_SUB_SC), v1);
      chk("cap_fall", {7'h0, c != 1}, {7'h0, v1[7]});
      wr(cha(3, `CCT_CH_SUB_SC), cct_byte_t'(c << 2));
    end
    end_of_test();
  end
endmodule : cct_timer_tb
